// ---- core/bhi_top.sv ----
// Summary of operation
// RULE1 - Rising external interrupt edge sets pending flag; code drops edges in idle with ext_irq_enable low
// RULE2 - Interrupt pin sampled in phase two
// RULE3 - Idle wake on enabled external edge, run handler
// RULE4 - Powerdown wake on external; handler only if enabled
// RULE5 - Outside master requests bus by low hold request
// RULE6 - Hold honoured only if pin special and enabled
// RULE7 - Low hold acknowledge means bus released
// RULE8 - Fetch flag high whole external fetch cycle
// RULE9 - Fetch flag low for external data accesses
// RULE10 - Fetch flag low for internal fetches
// RULE11 - Low interrupt-needs-bus reports pending interrupt
// RULE12 - Held: report interrupt only when running internally
// RULE13 - Need external while held: want bus, report later
// RULE14 - Interrupt during grant: report until request released
// RULE15 - Nonmaskable edge vectors through fixed location
// RULE16 - Nonmaskable input held beyond one state time
// RULE17 - Idle wake on nonmaskable edge, run handler
// RULE18 - Powerdown ignores nonmaskable edges
// RULE19 - Bus want asserted with or after acknowledge
// RULE20 - Acknowledge dropped before bus is driven again
`timescale 1ns/1ps
module bhi_top (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Configuration
	input wire logic [7:0] wsr,
	input wire logic hold_pin_special,
	input wire logic ext_irq_enable,
	// Power mode entry requests
	input wire logic enter_idle,
	input wire logic enter_pdown,
	// Bus controller
	input wire bhi_pkg::bhi_cycle_s cycle,
	input wire logic bus_idle,
	input wire logic ext_cycle_pending,
	input wire logic exec_internal,
	input wire logic irq_request,
	input wire logic irq_taken,
	// Pins in
	input wire logic ext_irq_in,
	input wire logic nmi_in,
	input wire logic hold_req_n,
	// Pins out
	output logic phase_clock_out,
	output logic hold_ack_n,
	output logic bus_want_n,
	output logic irq_bus_need_n,
	output logic instr_fetch_flag,
	output logic bus_drive_en,
	// Core events
	output bhi_pkg::bhi_irq_s irq_ev,
	output logic [15:0] nmi_vector_addr,
	output logic ext_irq_pending,
	output bhi_pkg::bhi_pm_e power_mode
);
	////////////////////////////////////////////////////////////////
	// Shared decodes
	// Bus given away to the outside master
	function automatic logic is_held(input bhi_pkg::bhi_hs_e s);
		return s == bhi_pkg::BHI_HS_HELD;
	endfunction

	// Power mode compare, used by wake and event logic
	function automatic logic in_mode(input bhi_pkg::bhi_pm_e s, input bhi_pkg::bhi_pm_e m);
		return s == m;
	endfunction

	////////////////////////////////////////////////////////////////
	// Phase clock and pin edges
	logic phase_high;
	logic phase2_en;
	logic ext_rise;
	logic nmi_rise;

	bhi_phase_gen #(
		.STATE_CYCLES(bhi_pkg::STATE_CYCLES)
	) u_phase (
		.clk(clk),
		.resetn(resetn),
		.phase_high(phase_high),
		.phase2_en(phase2_en)
	);

	bhi_edge_detect u_ext_edge (
		.clk(clk),
		.resetn(resetn),
		.sample_en(phase2_en), // [RULE2]
		.pin(ext_irq_in),
		.rise(ext_rise)
	);

	bhi_edge_detect u_nmi_edge (
		.clk(clk),
		.resetn(resetn),
		.sample_en(phase2_en), // [RULE16]
		.pin(nmi_in),
		.rise(nmi_rise)
	);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			phase_clock_out <= 1'b0;
		end else begin
			phase_clock_out <= phase_high;
		end
	end

	////////////////////////////////////////////////////////////////
	// Power modes
	bhi_pkg::bhi_pm_e pm_reg;
	logic wake_ext;
	logic wake_nmi;

	assign wake_ext = (in_mode(pm_reg, bhi_pkg::BHI_PM_IDLE)
		&& ext_rise && ext_irq_enable) // [RULE3]
		|| (in_mode(pm_reg, bhi_pkg::BHI_PM_PDOWN) && ext_rise); // [RULE4]
	assign wake_nmi = in_mode(pm_reg, bhi_pkg::BHI_PM_IDLE) && nmi_rise; // [RULE17] [RULE18]

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pm_reg <= bhi_pkg::BHI_PM_RUN;
		end else begin
			case (pm_reg)
				bhi_pkg::BHI_PM_RUN: begin
					if (enter_pdown) begin
						pm_reg <= bhi_pkg::BHI_PM_PDOWN;
					end else if (enter_idle) begin
						pm_reg <= bhi_pkg::BHI_PM_IDLE;
					end
				end
				bhi_pkg::BHI_PM_IDLE: begin
					if (wake_ext || wake_nmi) begin
						pm_reg <= bhi_pkg::BHI_PM_RUN;
					end
				end
				bhi_pkg::BHI_PM_PDOWN: begin
					if (wake_ext) begin
						pm_reg <= bhi_pkg::BHI_PM_RUN;
					end
				end
				default: begin
					pm_reg <= bhi_pkg::BHI_PM_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			power_mode <= bhi_pkg::BHI_PM_RUN;
		end else begin
			power_mode <= pm_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupt events
	logic ext_pend_reg;
	logic ext_edge_any;

	// Edge in run, and any edge accepted as a wake, latch pending
	assign ext_edge_any = ext_rise && (in_mode(pm_reg, bhi_pkg::BHI_PM_RUN) || wake_ext);

	// Set wins over clear so an edge in the clearing cycle is kept
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ext_pend_reg <= 1'b0;
		end else if (ext_edge_any) begin
			ext_pend_reg <= 1'b1; // [RULE1]
		end else if (irq_taken) begin
			ext_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ext_irq_pending <= 1'b0;
		end else begin
			ext_irq_pending <= ext_pend_reg || ext_edge_any;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_ev <= '0;
			nmi_vector_addr <= 16'h0000;
		end else begin
			irq_ev.ext_pend <= ext_edge_any;
			// Nonmaskable vector in run or on idle wake
			irq_ev.nmi_vector <= nmi_rise && !in_mode(pm_reg, bhi_pkg::BHI_PM_PDOWN); // [RULE15]
			irq_ev.wake <= wake_ext || wake_nmi;
			// Handler runs first unless powerdown exit with interrupt disabled
			irq_ev.run_isr <= wake_nmi || (wake_ext && ext_irq_enable); // [RULE3] [RULE4]
			nmi_vector_addr <= bhi_pkg::NMI_VECTOR_ADDR; // [RULE15]
		end
	end

	////////////////////////////////////////////////////////////////
	// Bus hold handshake
	bhi_pkg::bhi_hs_e hs_reg;
	logic hold_req;
	logic hold_enabled;

	// Pin in special function and protocol switched on
	assign hold_enabled = hold_pin_special && wsr[bhi_pkg::WSR_HOLD_EN_BIT]; // [RULE6]
	// Dropping the enable in mid-hold acts as a release
	assign hold_req = !hold_req_n && hold_enabled; // [RULE5] [RULE6]

	always_ff @(posedge clk) begin
		if (!resetn) begin
			hs_reg <= bhi_pkg::BHI_HS_OWN;
		end else begin
			case (hs_reg)
				bhi_pkg::BHI_HS_OWN: begin
					if (hold_req) begin
						hs_reg <= bhi_pkg::BHI_HS_GRANTING;
					end
				end
				bhi_pkg::BHI_HS_GRANTING: begin
					// Grant at the end of the current bus cycle
					if (!hold_req) begin
						hs_reg <= bhi_pkg::BHI_HS_OWN;
					end else if (bus_idle) begin
						hs_reg <= bhi_pkg::BHI_HS_HELD;
					end
				end
				bhi_pkg::BHI_HS_HELD: begin
					if (!hold_req) begin
						hs_reg <= bhi_pkg::BHI_HS_RETURNING;
					end
				end
				bhi_pkg::BHI_HS_RETURNING: begin
					hs_reg <= bhi_pkg::BHI_HS_OWN;
				end
				default: begin
					hs_reg <= bhi_pkg::BHI_HS_OWN;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			hold_ack_n <= bhi_pkg::HOLD_ACK_N_RST;
		end else begin
			hold_ack_n <= !(is_held(hs_reg) && hold_req); // [RULE7]
		end
	end

	// Bus driven only two cycles after acknowledge has gone high
	always_ff @(posedge clk) begin
		if (!resetn) begin
			bus_drive_en <= 1'b1;
		end else begin
			bus_drive_en <= hs_reg == bhi_pkg::BHI_HS_OWN && hold_ack_n; // [RULE20]
		end
	end

	logic want_next;

	// Low from the first pending external cycle until the request goes
	always_comb begin
		want_next = bus_want_n;
		if (!hold_req) begin
			want_next = 1'b1; // [RULE19]
		end else if (is_held(hs_reg) && ext_cycle_pending) begin
			want_next = 1'b0; // [RULE13] [RULE19]
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			bus_want_n <= bhi_pkg::BUS_WANT_N_RST;
		end else begin
			bus_want_n <= want_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupt needs bus
	logic deferred_reg;
	logic grant_irq_reg;
	logic need_next;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			grant_irq_reg <= 1'b0;
		end else if (hs_reg == bhi_pkg::BHI_HS_GRANTING && irq_request) begin
			grant_irq_reg <= 1'b1; // [RULE14]
		end else if (!hold_req) begin
			grant_irq_reg <= 1'b0;
		end
	end

	// Request during hold while running externally waits for release
	always_ff @(posedge clk) begin
		if (!resetn) begin
			deferred_reg <= 1'b0;
		end else if (is_held(hs_reg) && irq_request && !exec_internal) begin
			deferred_reg <= 1'b1; // [RULE13]
		end else if (hs_reg == bhi_pkg::BHI_HS_OWN || irq_taken) begin
			deferred_reg <= 1'b0;
		end
	end

	// Any of the three reasons pulls the pin low
	always_comb begin
		need_next = 1'b0;
		if (grant_irq_reg) begin
			need_next = 1'b1; // [RULE14]
		end
		if (is_held(hs_reg) && irq_request && exec_internal) begin
			need_next = 1'b1; // [RULE12]
		end
		if (deferred_reg && !hold_req) begin
			need_next = 1'b1; // [RULE11] [RULE13]
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_bus_need_n <= bhi_pkg::IRQ_NEED_N_RST;
		end else begin
			irq_bus_need_n <= !need_next; // [RULE11]
		end
	end

	////////////////////////////////////////////////////////////////
	// Instruction fetch flag
	always_ff @(posedge clk) begin
		if (!resetn) begin
			instr_fetch_flag <= bhi_pkg::FETCH_FLAG_RST;
		end else begin
			// Low for data, vectors, configuration reads and internal fetches
			instr_fetch_flag <= cycle.active && cycle.external && cycle.is_fetch; // [RULE8] [RULE9] [RULE10]
		end
	end
endmodule

// ---- core/bhi_pkg.sv ----
package bhi_pkg;

	// Clock and state time
	localparam int CLK_PERIOD_PS = 5000;
	localparam int STATE_TIME_NS = 10;
	localparam int STATE_CYCLES = (STATE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Window selection register bit that enables bus hold
	localparam int WSR_HOLD_EN_BIT = 7;

	// Nonmaskable vector location
	localparam logic [15:0] NMI_VECTOR_ADDR = 16'h203E;

	// Reset values
	localparam logic HOLD_ACK_N_RST = 1'b1;
	localparam logic IRQ_NEED_N_RST = 1'b1;
	localparam logic BUS_WANT_N_RST = 1'b1;
	localparam logic FETCH_FLAG_RST = 1'b0;

	// Power modes
	typedef enum logic [1:0] {
		BHI_PM_RUN,
		BHI_PM_IDLE,
		BHI_PM_PDOWN
	} bhi_pm_e;

	// Hold handshake states
	typedef enum logic [1:0] {
		BHI_HS_OWN,
		BHI_HS_GRANTING,
		BHI_HS_HELD,
		BHI_HS_RETURNING
	} bhi_hs_e;

	// Bus cycle description from the bus controller
	typedef struct packed {
		logic active;
		logic external;
		logic is_fetch;
	} bhi_cycle_s;

	// Interrupt events toward the core
	typedef struct packed {
		logic ext_pend;
		logic nmi_vector;
		logic wake;
		logic run_isr;
	} bhi_irq_s;

endpackage

// ---- core/bhi_edge_detect.sv ----
`timescale 1ns/1ps
module bhi_edge_detect (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Sampling strobe and pin
	input wire logic sample_en,
	input wire logic pin,
	// Rising edge seen at a sample
	output logic rise
);
	logic prev_reg;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			prev_reg <= 1'b0;
		end else if (sample_en) begin
			prev_reg <= pin;
		end
	end

	assign rise = sample_en && pin && !prev_reg;
endmodule

// ---- core/bhi_phase_gen.sv ----
`timescale 1ns/1ps
module bhi_phase_gen #(
	parameter int STATE_CYCLES = bhi_pkg::STATE_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Phase clock level and phase 2 sample strobe
	output logic phase_high,
	output logic phase2_en
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;

	// Wrap at the end of each state time
	assign cnt_next = (cnt_reg == 8'(STATE_CYCLES - 1)) ? 8'h00 : cnt_reg + 8'h01;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// From the next count, so the registered pin copy is high in phase 2
	assign phase_high = cnt_next >= 8'(STATE_CYCLES / 2);
	assign phase2_en = cnt_reg == 8'(STATE_CYCLES - 1);
endmodule

// ---- tb/bhi_properties.sv ----
`timescale 1ns/1ps
module bhi_props (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Inputs watched
	input wire logic [7:0] wsr,
	input wire logic hold_pin_special,
	input wire bhi_pkg::bhi_cycle_s cycle,
	input wire logic ext_cycle_pending,
	input wire logic hold_req_n,
	// Outputs watched
	input wire logic phase_clock_out,
	input wire logic hold_ack_n,
	input wire logic bus_want_n,
	input wire logic instr_fetch_flag,
	input wire logic bus_drive_en,
	input wire bhi_pkg::bhi_irq_s irq_ev,
	input wire logic [15:0] nmi_vector_addr,
	input wire logic ext_irq_pending,
	input wire bhi_pkg::bhi_pm_e power_mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_fetch_ext; cycle == 3'b111 |=> instr_fetch_flag; endproperty
	a_fetch_ext: assert property (p_fetch_ext) else $error("fetch flag low");
	property p_fetch_low; cycle.active && !(cycle.external && cycle.is_fetch) |=> !instr_fetch_flag;
	endproperty
	a_fetch_low: assert property (p_fetch_low) else $error("fetch flag high");
	property p_ack_rel; hold_req_n |=> hold_ack_n; endproperty
	a_ack_rel: assert property (p_ack_rel) else $error("ack without request");
	property p_hold_en; !(wsr[7] && hold_pin_special) |=> hold_ack_n; endproperty
	a_hold_en: assert property (p_hold_en) else $error("ack while hold disabled");
	property p_drive_back; $rose(hold_ack_n) |-> !bus_drive_en ##2 bus_drive_en; endproperty
	a_drive_back: assert property (p_drive_back) else $error("bus drive order");
	property p_want_ack; !bus_want_n |-> !hold_ack_n; endproperty
	a_want_ack: assert property (p_want_ack) else $error("want outside hold");
	property p_want_set; !hold_ack_n && !hold_req_n && ext_cycle_pending |=> !bus_want_n;
	endproperty
	a_want_set: assert property (p_want_set) else $error("want missing");
	property p_pend; irq_ev.ext_pend |-> ext_irq_pending; endproperty
	a_pend: assert property (p_pend) else $error("pending not set");
	property p_nmi; irq_ev.nmi_vector |-> nmi_vector_addr == 16'h203E; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi vector wrong");
	property p_nmi_pd; irq_ev.nmi_vector |-> power_mode != bhi_pkg::BHI_PM_PDOWN;
	endproperty
	a_nmi_pd: assert property (p_nmi_pd) else $error("nmi in powerdown");
	property p_phase; irq_ev.ext_pend |-> $past(phase_clock_out); endproperty
	a_phase: assert property (p_phase) else $error("pin sampled outside phase 2");
	c_held: cover property ($fell(hold_ack_n));
	c_want: cover property (!bus_want_n);
	c_wake: cover property (irq_ev.wake);
endmodule

bind bhi_top bhi_props bhi_props_i (.clk, .resetn, .wsr, .hold_pin_special, .cycle, .phase_clock_out,
	.ext_cycle_pending, .hold_req_n, .hold_ack_n, .bus_want_n, .instr_fetch_flag,
	.bus_drive_en, .irq_ev, .nmi_vector_addr, .ext_irq_pending, .power_mode);

// ---- tb/bhi_master_model.sv ----
`timescale 1ns/1ps
module bhi_master_model (
	// Clock
	input wire logic clk,
	// Bench control
	input wire logic want,
	input wire logic [3:0] lag,
	// Hold request pin
	output logic hold_req_n
);
	logic [3:0] wait_cnt;
	initial begin
		wait_cnt = 4'h0;
		hold_req_n = 1'b1;
	end
	// Request after a set delay, release at once
	always @(posedge clk) begin
		wait_cnt <= !want ? 4'h0 : (wait_cnt == 4'hF) ? wait_cnt : wait_cnt + 4'h1;
		hold_req_n <= !(want && wait_cnt >= lag);
	end
endmodule

// ---- tb/bhi_top_tb_top.sv ----
`timescale 1ns/1ps
module bhi_top_tb_top;
	logic clk = 1'b0, resetn = 1'b0, hold_pin_special = 1'b0, ext_irq_enable = 1'b0;
	logic enter_idle = 1'b0, enter_pdown = 1'b0, bus_idle = 1'b1, ext_cycle_pending = 1'b0;
	logic exec_internal = 1'b0, irq_request = 1'b0, irq_taken = 1'b0, ext_irq_in = 1'b0;
	logic nmi_in = 1'b0, want = 1'b0, hold_req_n, phase_clock_out, hold_ack_n, bus_want_n;
	logic irq_bus_need_n, instr_fetch_flag, bus_drive_en, ext_irq_pending;
	logic [7:0] wsr = 8'h00;
	logic [3:0] lag = 4'h0;
	logic [15:0] nmi_vector_addr;
	bhi_pkg::bhi_cycle_s cycle = '0;
	bhi_pkg::bhi_irq_s irq_ev, seen;
	bhi_pkg::bhi_pm_e power_mode;
	int num_errors = 0, cmp_count = 0, cyc = 0;
	always #2.5 clk = ~clk;
	bhi_top bhi_top_i (.clk, .resetn, .wsr, .hold_pin_special, .ext_irq_enable, .enter_idle,
		.enter_pdown, .cycle, .bus_idle, .ext_cycle_pending, .exec_internal, .irq_request,
		.irq_taken, .ext_irq_in, .nmi_in, .hold_req_n, .phase_clock_out, .hold_ack_n,
		.bus_want_n, .irq_bus_need_n, .instr_fetch_flag, .bus_drive_en, .irq_ev,
		.nmi_vector_addr, .ext_irq_pending, .power_mode);
	bhi_master_model bhi_master_model_i (.clk, .want, .lag, .hold_req_n);
	always @(posedge clk) begin
		seen <= seen | irq_ev;
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			num_errors++;
			final_report;
		end
	end
	////////////////////////////////////////////////////////////////
	task w(input int n);
		repeat (n) @(negedge clk);
	endtask
	task chk(input string name, input logic [19:0] seen_v, input logic [19:0] exp_v);
		cmp_count++;
		if (seen_v !== exp_v) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp_v, seen_v);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task pins(input logic [1:0] v);
		seen = '0;
		{nmi_in, ext_irq_in} = v; w(6);
		{nmi_in, ext_irq_in} = 2'b00; w(6);
	endtask
	task mode(input logic pd);
		enter_idle = !pd; enter_pdown = pd; w(1);
		enter_idle = 1'b0; enter_pdown = 1'b0; w(2);
		chk("mode", power_mode, pd ? bhi_pkg::BHI_PM_PDOWN : bhi_pkg::BHI_PM_IDLE);
	endtask
	task taken;
		irq_taken = 1'b1; w(1); irq_taken = 1'b0; w(1);
	endtask
	////////////////////////////////////////////////////////////////
	task t_phase;
		logic first;
		first = phase_clock_out;
		w(1); chk("phase_a", phase_clock_out, !first);
		w(1); chk("phase_b", phase_clock_out, first);
		$display("phase test done");
	endtask
	task t_fetch;
		for (int i = 0; i < 3; i++) begin
			cycle = (i == 0) ? 3'b111 : (i == 1) ? 3'b110 : 3'b101; w(2);
			chk("fetch", instr_fetch_flag, i == 0);
		end
		cycle = '0;
		$display("fetch test done");
	endtask
	task t_ext;
		pins(2'b01);
		chk("pend", {seen.ext_pend, ext_irq_pending}, 2'b11);
		taken; chk("clear", ext_irq_pending, 1'b0);
		mode(1'b0); pins(2'b01);
		chk("idle_off", {seen.wake, ext_irq_pending, power_mode}, {2'b00, bhi_pkg::BHI_PM_IDLE});
		pins(2'b10);
		ext_irq_enable = 1'b1; mode(1'b0); pins(2'b01);
		chk("idle", {seen.wake, seen.run_isr, power_mode}, {2'b11, bhi_pkg::BHI_PM_RUN});
		ext_irq_enable = 1'b0; mode(1'b1); pins(2'b01);
		chk("pdown", {seen.wake, seen.run_isr, power_mode}, {2'b10, bhi_pkg::BHI_PM_RUN});
		taken; $display("ext test done");
	endtask
	task t_nmi;
		pins(2'b10);
		chk("nmi", {seen.nmi_vector, nmi_vector_addr}, {1'b1, 16'h203E});
		mode(1'b0); pins(2'b10);
		chk("nmi_idle", {seen.wake, seen.nmi_vector, power_mode}, {2'b11, bhi_pkg::BHI_PM_RUN});
		mode(1'b1); pins(2'b10);
		chk("nmi_pd", {seen.wake, seen.nmi_vector, power_mode}, {2'b00, bhi_pkg::BHI_PM_PDOWN});
		pins(2'b01); taken; $display("nmi test done");
	endtask
	task t_hold;
		want = 1'b1; w(8); chk("no_en", hold_ack_n, 1'b1);
		want = 1'b0; w(1);
		wsr = 8'h80; hold_pin_special = 1'b1; bus_idle = 1'b0; w(2);
		want = 1'b1; irq_request = 1'b1; w(6);
		chk("granting", {hold_ack_n, irq_bus_need_n}, 2'b10);
		bus_idle = 1'b1; w(4);
		chk("held", {hold_ack_n, bus_drive_en, irq_bus_need_n}, 3'b000);
		ext_cycle_pending = 1'b1; w(2); chk("want", bus_want_n, 1'b0);
		want = 1'b0; w(5);
		chk("release", {hold_ack_n, bus_want_n, bus_drive_en}, 3'b111);
		irq_request = 1'b0; ext_cycle_pending = 1'b0; taken;
		lag = 4'h3; exec_internal = 1'b1; want = 1'b1; w(10);
		irq_request = 1'b1; w(3); chk("internal", irq_bus_need_n, 1'b0);
		want = 1'b0; irq_request = 1'b0; w(5); taken;
		exec_internal = 1'b0; want = 1'b1; w(10);
		irq_request = 1'b1; w(3); chk("defer", irq_bus_need_n, 1'b1);
		want = 1'b0; w(4); chk("after", irq_bus_need_n, 1'b0);
		irq_request = 1'b0; taken; $display("hold test done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		seen = '0;
		w(3); resetn = 1'b1; w(1);
		chk("reset", {hold_ack_n, bus_want_n, irq_bus_need_n, instr_fetch_flag, bus_drive_en,
			power_mode}, {5'b11101, bhi_pkg::BHI_PM_RUN});
		t_phase;
		t_fetch;
		t_ext;
		t_nmi;
		t_hold;
		final_report;
	end
endmodule
